// File: common/mfts_pkg.sv
// Constants, types and helpers for the memory fault test sequencer
package mfts_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int GRP_W  = 3;
   localparam int STEP_W = 4;
   localparam int RET_W  = 17;

   localparam logic [STEP_W-1:0] SEL_LAST   = 4'h9;
   localparam logic [STEP_W-1:0] RDEN_LAST  = 4'h5;
   localparam logic [STEP_W-1:0] WREC_LAST  = 4'h5;
   localparam logic [STEP_W-1:0] MARCH_LAST = 4'h4;
   localparam logic [2:0]        BG_LAST    = 3'h7;
   localparam logic [GRP_W-1:0]  GRP_LAST   = 3'h7;
   localparam logic [ADDR_W-1:0] ADDR_LAST  = 6'h3F;
   localparam logic [DATA_W-1:0] ONES       = 8'hFF;
   localparam logic [DATA_W-1:0] ZEROS      = 8'h00;

   localparam int CLK_PERIOD_NS = 100;
   localparam int PAUSE_TIME_US = 10000;
   localparam int PAUSE_CYCLES  = PAUSE_TIME_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_SEL   = 4'h1,
      ST_RDEN  = 4'h2,
      ST_WREC  = 4'h3,
      ST_INIT  = 4'h4,
      ST_UP    = 4'h5,
      ST_DOWN  = 4'h6,
      ST_PAUSE = 4'h7,
      ST_DONE  = 4'h8
   } mfts_state_t;

   // Three-bit pattern repeated along the word: every bit triple sees it
   function automatic logic [DATA_W-1:0] bg_word(input logic [2:0] p);
      logic [DATA_W-1:0] w;
      w = ZEROS;
      for (int i = 0; i < DATA_W; i++) begin
         w[i] = p[i % 3];
      end
      return w;
   endfunction
endpackage

// File: src/mfts_sequencer.sv
// Memory fault test sequencer driving a two-port SRAM
`timescale 1ns/1ps
module mfts_sequencer #(
   parameter int unsigned PAUSE_CYCLES = mfts_pkg::PAUSE_CYCLES
) (
   input  wire logic                        clk,
   input  wire logic                        resetn,
   input  wire logic                        start,
   input  wire logic                        output_hold_when_deselected,
   input  wire logic                        output_hold_when_read_disabled,
   input  wire logic                        pause_en,
   output logic                             busy,
   output logic                             done,
   output logic                             fail,
   output logic                             a_sel,
   output logic                             a_re,
   output logic                             a_we,
   output logic [mfts_pkg::ADDR_W-1:0]      a_addr,
   output logic [mfts_pkg::DATA_W-1:0]      a_wdata,
   input  wire logic [mfts_pkg::DATA_W-1:0] a_rdata,
   output logic                             b_sel,
   output logic                             b_re,
   output logic [mfts_pkg::ADDR_W-1:0]      b_addr
);
   logic [1:0]                    rst_sync_q;
   logic                          rst_n;
   mfts_pkg::mfts_state_t         state_q, state_d, resume_q, resume_d;
   logic [mfts_pkg::STEP_W-1:0]   step_q, step_d;
   logic [mfts_pkg::ADDR_W-1:0]   cnt_q, cnt_d;
   logic [2:0]                    bg_q, bg_d;
   logic [mfts_pkg::RET_W-1:0]    ret_q, ret_d;
   logic                          a_sel_q, a_sel_d, a_re_q, a_re_d, a_we_q, a_we_d;
   logic [mfts_pkg::ADDR_W-1:0]   a_addr_q, a_addr_d, b_addr_q, b_addr_d;
   logic [mfts_pkg::DATA_W-1:0]   a_wdata_q, a_wdata_d, exp_q, exp_d, exp2_q, exp2_d;
   logic                          b_sel_q, b_sel_d, b_re_q, b_re_d;
   logic                          strb_q, strb_d, strb2_q, strb2_d, fail_q, fail_d;
   logic                          g_row, g_we, g_re, g_sel, g_one;
   logic                          m_rd, m_inv;
   logic [mfts_pkg::DATA_W-1:0]   m_pat;
   logic [2:0]                    nb_row;
   mfts_pkg::mfts_state_t         after_grp;

   // Reset released through two flops, asserted at once
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_comb begin
      state_d   = state_q;
      resume_d  = resume_q;
      step_d    = step_q;
      cnt_d     = cnt_q;
      bg_d      = bg_q;
      ret_d     = ret_q;
      a_sel_d   = 1'b0;
      a_re_d    = 1'b0;
      a_we_d    = 1'b0;
      a_addr_d  = a_addr_q;
      a_wdata_d = a_wdata_q;
      b_sel_d   = 1'b0;
      b_re_d    = 1'b0;
      b_addr_d  = b_addr_q;
      strb_d    = 1'b0;
      exp_d     = exp_q;
      g_row     = 1'b0;
      g_we      = 1'b0;
      g_sel     = 1'b1;
      g_one     = 1'b0;
      g_re      = 1'b1;
      after_grp = state_q;
      m_rd      = (step_q == 4'h0) || (step_q == 4'h1) || (step_q == 4'h4);
      // Steps 2..4 carry the inverse; descending pass swaps polarity
      m_inv     = (step_q >= 4'h2) ^ (state_q == mfts_pkg::ST_DOWN);
      m_pat     = mfts_pkg::bg_word(bg_q) ^ (m_inv ? mfts_pkg::ONES : mfts_pkg::ZEROS);
      // Neighbour row next in this pass holds the opposite data, except from the last row, where it wraps to the visited first row
      nb_row    = (state_q == mfts_pkg::ST_DOWN) ? cnt_q[4:2] - 3'h1 : cnt_q[4:2] + 3'h1;
      unique case (state_q)
         mfts_pkg::ST_IDLE, mfts_pkg::ST_DONE: begin
            if (start) begin
               step_d = 4'h0;
               cnt_d  = 6'h00;
               bg_d   = 3'h0;
               if (output_hold_when_deselected) begin
                  state_d = mfts_pkg::ST_SEL;
               end else if (output_hold_when_read_disabled) begin
                  state_d = mfts_pkg::ST_RDEN;
               end else begin
                  state_d = mfts_pkg::ST_WREC;
               end
            end
         end
         mfts_pkg::ST_SEL, mfts_pkg::ST_RDEN, mfts_pkg::ST_WREC: begin
            if (state_q == mfts_pkg::ST_SEL) begin
               // Deselected reads rely on the output holding the last read
               unique case (step_q)
                  4'h0: begin g_we = 1'b1; g_one = 1'b1; end
                  4'h1: begin g_we = 1'b1; g_row = 1'b1; end
                  4'h2: begin g_one = 1'b1; end
                  4'h3: begin g_row = 1'b1; end
                  4'h4: begin g_sel = 1'b0; end
                  4'h5: begin g_sel = 1'b0; g_we = 1'b1; end
                  4'h6: begin g_one = 1'b1; end
                  4'h7: begin g_sel = 1'b0; g_row = 1'b1; g_one = 1'b1; end
                  4'h8: begin g_sel = 1'b0; g_we = 1'b1; g_row = 1'b1; g_one = 1'b1; end
                  default: begin g_row = 1'b1; end
               endcase
               after_grp = output_hold_when_read_disabled ? mfts_pkg::ST_RDEN
                                                          : mfts_pkg::ST_WREC;
            end else if (state_q == mfts_pkg::ST_RDEN) begin
               // Disabled reads expect the held value of the previous read
               unique case (step_q)
                  4'h0: begin g_we = 1'b1; g_one = 1'b1; end
                  4'h1: begin g_we = 1'b1; g_row = 1'b1; end
                  4'h2: begin g_one = 1'b1; end
                  4'h3: begin g_re = 1'b0; g_row = 1'b1; g_one = 1'b1; end
                  4'h4: begin g_row = 1'b1; end
                  default: begin g_re = 1'b0; end
               endcase
               after_grp = mfts_pkg::ST_WREC;
            end else begin
               // Read of row A follows the row B write at once
               unique case (step_q)
                  4'h0: begin g_we = 1'b1; g_one = 1'b1; end
                  4'h1: begin g_we = 1'b1; g_row = 1'b1; end
                  4'h2: begin g_one = 1'b1; end
                  4'h3: begin g_we = 1'b1; end
                  4'h4: begin g_we = 1'b1; g_row = 1'b1; g_one = 1'b1; end
                  default: begin end
               endcase
               after_grp = mfts_pkg::ST_INIT;
            end
            a_sel_d   = g_sel;
            a_we_d    = g_we;
            a_re_d    = g_re && !g_we;
            // Rows 0 and 1 only; bank and column come from the group counter
            a_addr_d  = {cnt_q[2], 2'b00, g_row, cnt_q[1:0]};
            a_wdata_d = g_one ? mfts_pkg::ONES : mfts_pkg::ZEROS;
            strb_d    = !g_we;
            exp_d     = g_one ? mfts_pkg::ONES : mfts_pkg::ZEROS;
            step_d    = step_q + 4'h1;
            if ((state_q == mfts_pkg::ST_SEL && step_q == mfts_pkg::SEL_LAST) ||
                (state_q == mfts_pkg::ST_RDEN && step_q == mfts_pkg::RDEN_LAST) ||
                (state_q == mfts_pkg::ST_WREC && step_q == mfts_pkg::WREC_LAST)) begin
               step_d = 4'h0;
               cnt_d  = {3'h0, cnt_q[2:0] + 3'h1};
               if (cnt_q[2:0] == mfts_pkg::GRP_LAST) begin
                  cnt_d   = 6'h00;
                  state_d = after_grp;
               end
            end
         end
         mfts_pkg::ST_INIT: begin
            a_sel_d   = 1'b1;
            a_we_d    = 1'b1;
            a_addr_d  = cnt_q;
            a_wdata_d = mfts_pkg::bg_word(bg_q);
            cnt_d     = cnt_q + 6'h01;
            if (cnt_q == mfts_pkg::ADDR_LAST) begin
               cnt_d = 6'h00;
               if (pause_en) begin
                  state_d  = mfts_pkg::ST_PAUSE;
                  resume_d = mfts_pkg::ST_UP;
               end else begin
                  state_d = mfts_pkg::ST_UP;
               end
            end
         end
         mfts_pkg::ST_UP, mfts_pkg::ST_DOWN: begin
            // Read twice, write inverse twice, read back: disturb then transition
            a_sel_d   = 1'b1;
            a_we_d    = !m_rd;
            a_re_d    = m_rd;
            a_addr_d  = cnt_q;
            a_wdata_d = m_pat;
            strb_d    = m_rd;
            exp_d     = m_pat;
            // Shadow port reads the same row, or the column's neighbour row next in pass order, wrapping within the bank
            b_sel_d   = 1'b1;
            b_re_d    = 1'b1;
            b_addr_d  = m_rd ? cnt_q
                             : {cnt_q[5], nb_row, cnt_q[1:0]};
            step_d    = step_q + 4'h1;
            if (step_q == mfts_pkg::MARCH_LAST) begin
               step_d = 4'h0;
               if (state_q == mfts_pkg::ST_UP) begin
                  cnt_d = cnt_q + 6'h01;
                  if (cnt_q == mfts_pkg::ADDR_LAST) begin
                     // Descending pass starts from the top address
                     cnt_d = mfts_pkg::ADDR_LAST;
                     if (pause_en) begin
                        state_d  = mfts_pkg::ST_PAUSE;
                        resume_d = mfts_pkg::ST_DOWN;
                     end else begin
                        state_d = mfts_pkg::ST_DOWN;
                     end
                  end
               end else begin
                  cnt_d = cnt_q - 6'h01;
                  if (cnt_q == 6'h00) begin
                     cnt_d   = 6'h00;
                     bg_d    = bg_q + 3'h1;
                     state_d = (bg_q == mfts_pkg::BG_LAST) ? mfts_pkg::ST_DONE
                                                           : mfts_pkg::ST_INIT;
                  end
               end
            end
         end
         mfts_pkg::ST_PAUSE: begin
            // Memory left idle so leaking cells lose their charge
            ret_d = ret_q + 17'h00001;
            if (ret_q >= mfts_pkg::RET_W'(PAUSE_CYCLES - 1)) begin
               ret_d   = 17'h00000;
               state_d = resume_q;
               cnt_d   = (resume_q == mfts_pkg::ST_DOWN) ? mfts_pkg::ADDR_LAST : 6'h00;
            end
         end
         default: begin
            state_d = mfts_pkg::ST_IDLE;
         end
      endcase
      // Read lands one cycle after the port flops; compare follows it
      strb2_d = strb_q;
      exp2_d  = exp_q;
      // A start refused while busy leaves the flag alone
      fail_d  = (strb2_q && (a_rdata != exp2_q)) || (fail_q && !(start && !busy));
   end

   // One operation issued per clock, nothing stretched
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= mfts_pkg::ST_IDLE;
         resume_q  <= mfts_pkg::ST_IDLE;
         step_q    <= 4'h0;
         cnt_q     <= 6'h00;
         bg_q      <= 3'h0;
         ret_q     <= 17'h00000;
         a_sel_q   <= 1'b0;
         a_re_q    <= 1'b0;
         a_we_q    <= 1'b0;
         a_addr_q  <= 6'h00;
         a_wdata_q <= 8'h00;
         b_sel_q   <= 1'b0;
         b_re_q    <= 1'b0;
         b_addr_q  <= 6'h00;
         strb_q    <= 1'b0;
         strb2_q   <= 1'b0;
         exp_q     <= 8'h00;
         exp2_q    <= 8'h00;
         fail_q    <= 1'b0;
      end else begin
         state_q   <= state_d;
         resume_q  <= resume_d;
         step_q    <= step_d;
         cnt_q     <= cnt_d;
         bg_q      <= bg_d;
         ret_q     <= ret_d;
         a_sel_q   <= a_sel_d;
         a_re_q    <= a_re_d;
         a_we_q    <= a_we_d;
         a_addr_q  <= a_addr_d;
         a_wdata_q <= a_wdata_d;
         b_sel_q   <= b_sel_d;
         b_re_q    <= b_re_d;
         b_addr_q  <= b_addr_d;
         strb_q    <= strb_d;
         strb2_q   <= strb2_d;
         exp_q     <= exp_d;
         exp2_q    <= exp2_d;
         fail_q    <= fail_d;
      end
   end

   assign a_sel   = a_sel_q;
   assign a_re    = a_re_q;
   assign a_we    = a_we_q;
   assign a_addr  = a_addr_q;
   assign a_wdata = a_wdata_q;
   assign b_sel   = b_sel_q;
   assign b_re    = b_re_q;
   assign b_addr  = b_addr_q;
   assign fail    = fail_q;
   assign busy    = (state_q != mfts_pkg::ST_IDLE) && (state_q != mfts_pkg::ST_DONE);
   // Done waits for the last compares still in flight
   assign done    = (state_q == mfts_pkg::ST_DONE) && !strb_q && !strb2_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_fail_sticky: assert property (fail_q && !start |=> fail_q)
      else $error("fail flag dropped without start");
   chk_miscompare_fail: assert property (strb2_q && a_rdata != exp2_q |=> fail_q)
      else $error("miscompare not latched");
   chk_sel_skipped: assert property (!busy && start && !output_hold_when_deselected
      |=> state_q != mfts_pkg::ST_SEL)
      else $error("select test run with hold option off");
   chk_rden_skipped: assert property (state_q == mfts_pkg::ST_SEL
      && !output_hold_when_read_disabled |-> state_d != mfts_pkg::ST_RDEN)
      else $error("read enable test run with hold option off");
   chk_low_rows_only: assert property ((state_q inside {mfts_pkg::ST_SEL,
      mfts_pkg::ST_RDEN}) |=> a_addr_q[4:3] == 2'b00)
      else $error("select or read enable test left rows 0 and 1");
   chk_shadow_same_row: assert property (a_re_q && b_re_q |-> b_addr_q == a_addr_q)
      else $error("shadow read not on the active address");
   chk_rw_opposite: assert property (a_we_q && b_re_q |->
      b_addr_q[1:0] == a_addr_q[1:0] && b_addr_q[4:2] != a_addr_q[4:2])
      else $error("concurrent read not in the written column");
   chk_write_twice: assert property (a_we_q && state_q == mfts_pkg::ST_UP && step_q == 4'h4
      |-> $past(a_we_q, 1) && $past(a_wdata_q, 1) == a_wdata_q)
      else $error("inverse write not repeated");
   chk_double_read: assert property (state_q == mfts_pkg::ST_UP && step_q == 4'h0
      |=> a_re_q ##1 a_re_q && $stable(a_addr_q))
      else $error("back to back reads missing");
   chk_pause_idle: assert property (state_q == mfts_pkg::ST_PAUSE
      && $past(state_q) == mfts_pkg::ST_PAUSE |-> !a_sel_q && !b_sel_q)
      else $error("memory accessed during retention pause");
   chk_rden_hold: assert property (state_q == mfts_pkg::ST_RDEN && step_q == 4'h3
      |=> a_sel_q && !a_re_q && !a_we_q && exp_q == mfts_pkg::ONES)
      else $error("read enable off read expects wrong value");

   cov_done: cover property (state_q == mfts_pkg::ST_DOWN ##1 state_q == mfts_pkg::ST_DONE);
   cov_pause: cover property (state_q == mfts_pkg::ST_PAUSE ##1 state_q == mfts_pkg::ST_DOWN);
   cov_fail: cover property (!fail_q ##1 fail_q);
   cov_sel_run: cover property (state_q == mfts_pkg::ST_SEL ##1 state_q == mfts_pkg::ST_RDEN);
endmodule

// File: testbench/mfts_sram_model.sv
// Behavioural two-port SRAM on the far side of the sequencer, port A modelled
`timescale 1ns/1ps
module mfts_sram_model #(
   parameter logic [mfts_pkg::ADDR_W-1:0] STUCK_ADDR = 6'h10
) (
   input  wire logic                        clk,
   input  wire logic                        a_sel,
   input  wire logic                        a_re,
   input  wire logic                        a_we,
   input  wire logic [mfts_pkg::ADDR_W-1:0] a_addr,
   input  wire logic [mfts_pkg::DATA_W-1:0] a_wdata,
   input  wire logic                        stuck_en,
   output logic [mfts_pkg::DATA_W-1:0]      a_rdata
);
   logic [mfts_pkg::DATA_W-1:0] mem [64];

   // Arbitrary power-up contents so an early unwritten read is not all zero
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 8'hA5;
      end
      a_rdata = 8'h5A;
   end

   always @(posedge clk) begin
      if (a_sel && a_we) begin
         mem[a_addr] <= a_wdata;
      end
      // Output holds last read when deselected or read enable low
      if (a_sel && a_re) begin
         a_rdata <= mem[a_addr] | ((stuck_en && a_addr == STUCK_ADDR) ? 8'h01 : 8'h00);
      end
   end
endmodule

// File: testbench/memory_fault_test_sequencer_test.sv
// Self-checking bench for the memory fault test sequencer
`timescale 1ns/1ps
module memory_fault_test_sequencer_test;
   localparam int PAUSE   = 8;
   localparam int TIMEOUT = 50000;

   logic                        clk      = 1'b0;
   logic                        resetn   = 1'b0;
   logic                        start    = 1'b0;
   logic                        hold_sel = 1'b1;
   logic                        hold_re  = 1'b1;
   logic                        pause_en = 1'b0;
   logic                        stuck_en = 1'b0;
   logic                        busy;
   logic                        done;
   logic                        fail;
   logic                        a_sel;
   logic                        a_re;
   logic                        a_we;
   logic [mfts_pkg::ADDR_W-1:0] a_addr;
   logic [mfts_pkg::DATA_W-1:0] a_wdata;
   logic [mfts_pkg::DATA_W-1:0] a_rdata;
   logic                        b_sel;
   logic                        b_re;
   logic [mfts_pkg::ADDR_W-1:0] b_addr;
   int                          mismatches   = 0;
   int                          total_checks = 0;
   int                          cycles       = 0;
   int                          n_wr         = 0;
   int                          n_rd         = 0;
   int                          n_shadow     = 0;
   int                          n_opp        = 0;
   int                          n_busy       = 0;
   int                          busy_plain   = 0;
   int                          busy_paused  = 0;

   always #50 clk = ~clk;

   mfts_sequencer #(.PAUSE_CYCLES(PAUSE)) i_mfts_sequencer (
      .clk                            (clk),
      .resetn                         (resetn),
      .start                          (start),
      .output_hold_when_deselected    (hold_sel),
      .output_hold_when_read_disabled (hold_re),
      .pause_en                       (pause_en),
      .busy                           (busy),
      .done                           (done),
      .fail                           (fail),
      .a_sel                          (a_sel),
      .a_re                           (a_re),
      .a_we                           (a_we),
      .a_addr                         (a_addr),
      .a_wdata                        (a_wdata),
      .a_rdata                        (a_rdata),
      .b_sel                          (b_sel),
      .b_re                           (b_re),
      .b_addr                         (b_addr)
   );

   mfts_sram_model i_mfts_sram_model (
      .clk      (clk),
      .a_sel    (a_sel),
      .a_re     (a_re),
      .a_we     (a_we),
      .a_addr   (a_addr),
      .a_wdata  (a_wdata),
      .stuck_en (stuck_en),
      .a_rdata  (a_rdata)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Port activity counted at the edge where the memory samples it
   always @(posedge clk) begin
      cycles++;
      if (cycles == TIMEOUT) begin
         mismatches++;
         end_of_test();
      end
      if (a_sel && a_we) n_wr++;
      if (a_sel && a_re) n_rd++;
      if (busy === 1'b1) n_busy++;
      if (a_sel && a_re && b_sel && b_re && b_addr === a_addr) n_shadow++;
      if (a_sel && a_we && b_sel && b_re) begin
         check({b_addr[5], b_addr[1:0], b_addr[4:2] != a_addr[4:2]},
               {a_addr[5], a_addr[1:0], 1'b1});
         if (i_mfts_sram_model.mem[b_addr] === ~a_wdata) n_opp++;
      end
   end

   // One whole run; a second start mid-run must be ignored
   task automatic run(input logic hs, input logic hr, input logic pe, input logic again);
      int n;
      @(posedge clk);
      #10;
      hold_sel = hs;
      hold_re  = hr;
      pause_en = pe;
      n_wr     = 0;
      n_rd     = 0;
      n_shadow = 0;
      n_opp    = 0;
      n_busy   = 0;
      start    = 1'b1;
      @(posedge clk);
      #10;
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 10000) begin
         @(posedge clk);
         #10;
         start = (again && n == 500);
         n++;
      end
      check(done, 1'b1);
   endtask

   task automatic t_reset();
      check({busy, done, fail, a_sel, a_we, b_sel}, 6'h00);
      $display("test reset finished");
   endtask

   task automatic t_clean();
      run(1'b1, 1'b1, 1'b0, 1'b0);
      busy_plain = n_busy;
      check(fail, 1'b0);
      check(n_wr, 2624);
      check(n_rd, 3136);
      check(n_shadow, 3072);
      check(n_opp, 1792);
      $display("test clean run finished");
   endtask

   task automatic t_skip();
      run(1'b0, 1'b0, 1'b0, 1'b1);
      check(n_wr, 2592);
      check(n_rd, 3088);
      check(fail, 1'b0);
      $display("test skipped hold tests finished");
   endtask

   task automatic t_pause();
      run(1'b1, 1'b1, 1'b1, 1'b0);
      busy_paused = n_busy;
      check(busy_paused - busy_plain >= 16 * PAUSE, 1'b1);
      check(n_wr, 2624);
      check(fail, 1'b0);
      $display("test retention pause finished");
   endtask

   task automatic t_fault();
      stuck_en = 1'b1;
      run(1'b1, 1'b1, 1'b0, 1'b0);
      check(fail, 1'b1);
      repeat (5) @(posedge clk);
      #10;
      check(fail, 1'b1);
      stuck_en = 1'b0;
      run(1'b1, 1'b1, 1'b0, 1'b0);
      check(fail, 1'b0);
      $display("test stuck cell finished");
   endtask

   initial begin
      repeat (3) @(posedge clk);
      #10;
      t_reset();
      resetn = 1'b1;
      repeat (3) @(posedge clk);
      t_clean();
      t_skip();
      t_pause();
      t_fault();
      end_of_test();
   end
endmodule
